/* lpw_regs.vh */
/*
  register offsets, field positions, reset values and timing counts of the
  low-power mode and wake-up controller.
  assumes a 125 MHz system clock and word-aligned ahb-lite registers.
*/
`ifndef LPW_REGS_VH
`define LPW_REGS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define LPW_ADDR_PMCFG      12'h000
`define LPW_ADDR_SUPPLY     12'h004
`define LPW_ADDR_STATUS     12'h008

// ----------------------------------------------------------------------------
// power mode config fields
// ----------------------------------------------------------------------------
`define LPW_BIT_SLEEP       7
`define LPW_BIT_SUSPEND     6
`define LPW_BIT_CLEAR       5
`define LPW_BIT_RSTWAKE     4
`define LPW_NUM_SRC         4

// ----------------------------------------------------------------------------
// supply config fields
// ----------------------------------------------------------------------------
`define LPW_BIT_FLOAT       1
`define LPW_BIT_TWOCELL     0
`define LPW_SUPPLY_RST      2'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define LPW_FLAG_HIDE_CYC   2'h2
`define LPW_OSC_START_NS    100
`define LPW_CLK_NS          8
`define LPW_OSC_START_CYC   ((`LPW_OSC_START_NS + `LPW_CLK_NS - 1) / `LPW_CLK_NS)

`endif

/* lpw_edge_det.v */
/*
  edge detector for the wake-up event inputs.
  assumes the inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ns
module lpw_edge_det (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_sync_n,
  // events
  input  wire [4:0] lvl_in,
  output wire [4:0] rise_out,
  output wire [4:0] fall_out
);
  reg [4:0] prev_q;

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // reset pin idles high: no false edge right after reset
      prev_q <= 5'h10;
    end else begin
      prev_q <= lvl_in;
    end
  end

  assign rise_out = lvl_in & ~prev_q;
  assign fall_out = ~lvl_in & prev_q;
endmodule // lpw_edge_det

/* lpw_ahb_slave.v */
/*
  ahb-lite slave front end: captures the address phase and yields one
  write strobe or read select in the data phase.
  assumes single word transfers; always zero wait states, okay response.
*/
`timescale 1ns/1ns
module lpw_ahb_slave (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_sync_n,
  // ahb-lite
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire        hready,
  // decoded data phase
  output reg         wr_q,
  output reg         rd_q,
  output reg  [11:0] addr_q
);
  wire take;

  assign take = hsel & hready & htrans[1];

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end
endmodule // lpw_ahb_slave

/* lpw_ctrl.v */
/*
  low-power mode and wake-up controller: suspend and sleep entry, wake-up
  matrix, sticky wake flags, clock gate, oscillator and supply controls.
  assumes event inputs are synchronous to clk_sys, which is the free
  running low-power clock that keeps this unit alive in both modes.
*/
// Functional notes
// - suspend gates the system clock and stops oscillators until wake-up.
// - for two clocks after suspend wake, flags read back zero.
// - wake sources: osc fail, alarm, port match, comparator rising edge.
// - a short reset pin glitch ends suspend.
// - sleep turns core regulator off, ram moves to battery supply.
// - sleep in one-cell disables converter; two-cell keeps comparators only.
// - digital output pins hold their last state during sleep.
// - one-cell sleep ties analog rail to battery unless float bit set.
// - state preserved through sleep; execution resumes at next instruction.
// - comparator wake from sleep only counts in two-cell mode.
// - any reset pin falling edge ends sleep.
// - reset pin is always a wake source, no enable.
// - flags update on every event, enabled or not, except comparator edges in one-cell sleep.
// - entry refused while any enabled flag is set.
// - writing bit 7 of config register enters sleep.
// - writing bit 5 clears all wake flags.
`timescale 1ns/1ns
`include "lpw_regs.vh"
module lpw_ctrl (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // ahb-lite
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // wake events
  input  wire        rtc_osc_fail,
  input  wire        rtc_alarm,
  input  wire        port_match,
  input  wire        cmp_out,
  input  wire        rst_pin_n,
  // pin hold input
  input  wire [7:0]  port_out_in,
  // power controls
  output reg         sys_clk_en,
  output reg         osc_en,
  output reg         core_reg_en,
  output reg         ram_on_battery,
  output reg         dcdc_en,
  output reg         analog_rail_to_bat,
  output reg         analog_rail_float,
  output reg         cmp_keep_on,
  output reg         pin_hold,
  output reg  [7:0]  port_out,
  output reg         cpu_resume,
  output reg         low_power_active
);
  // --------------------------------------------------------------------------
  // reset synchroniser and states
  // --------------------------------------------------------------------------
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_SUSP  = 4'b0010;
  localparam [3:0] ST_SLEEP = 4'b0100;
  localparam [3:0] ST_WAKE  = 4'b1000;
  localparam integer OSC_CYC_N = `LPW_OSC_START_CYC;
  localparam [7:0] OSC_CYC  = OSC_CYC_N[7:0];

  reg        rst_m_q;
  reg        rst_s_q;
  wire       rst_sync_n;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_sync_n = rst_s_q;

  // --------------------------------------------------------------------------
  // bus front end and event edges
  // --------------------------------------------------------------------------
  wire        wr;
  wire        rd_take;
  wire [11:0] addr;
  wire [4:0]  rise;
  wire [4:0]  fall;

  // read data leaves on the address-phase edge so it stands in the data phase
  assign rd_take = hsel & hready & htrans[1] & ~hwrite;

  lpw_ahb_slave u_bus (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hready     (hready),
    .wr_q       (wr),
    .rd_q       (),
    .addr_q     (addr)
  );

  lpw_edge_det u_edge (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .lvl_in     ({rst_pin_n, rtc_osc_fail, rtc_alarm, port_match, cmp_out}),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [3:0] en_q;
  reg [4:0] flag_q;
  reg [4:0] flag_d;
  reg [1:0] supply_q;
  reg [1:0] hide_q;
  reg [7:0] osc_cnt_q;
  reg [4:0] ev;
  reg       wr_cfg;
  reg       enter_sleep;
  reg       enter_susp;
  reg       wake_hit;
  reg [3:0] en_d;

  wire [`LPW_NUM_SRC-1:0] wdat_en;
  wire       two_cell;

  assign wdat_en  = hwdata[`LPW_NUM_SRC-1:0];
  assign two_cell = supply_q[`LPW_BIT_TWOCELL];

  // --------------------------------------------------------------------------
  // wake events and flags
  // --------------------------------------------------------------------------
  always @* begin
    ev[3] = rise[3];
    ev[2] = rise[2];
    ev[1] = rise[1];
    ev[0] = rise[0] & (two_cell | ~state_q[2]);
    ev[4] = fall[4];
    wr_cfg      = wr & (addr == `LPW_ADDR_PMCFG);
    enter_sleep = wr_cfg & hwdata[`LPW_BIT_SLEEP];
    enter_susp  = wr_cfg & hwdata[`LPW_BIT_SUSPEND] & ~hwdata[`LPW_BIT_SLEEP];
    flag_d = flag_q;
    if (wr_cfg && hwdata[`LPW_BIT_CLEAR]) begin
      flag_d = 5'h00;
    end
    flag_d = flag_d | ev;
    wake_hit = ev[4] | (|(ev[3:0] & en_q));
  end

  // --------------------------------------------------------------------------
  // mode state machine
  // --------------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    en_d    = en_q;
    case (state_q)
      ST_RUN: begin
        // refuse entry while an enabled flag is set
        if ((enter_sleep || enter_susp) && !(|(flag_d[3:0] & wdat_en))
            && !flag_d[4]) begin
          // enables taken from the entry write only
          en_d = wdat_en;
          state_d = enter_sleep ? ST_SLEEP : ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (wake_hit) begin
          state_d = ST_WAKE;
          en_d    = 4'h0;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          state_d = ST_WAKE;
          en_d    = 4'h0;
        end
      end
      ST_WAKE: begin
        // oscillators settle before the clock is ungated
        if (osc_cnt_q == OSC_CYC) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q   <= ST_RUN;
      en_q      <= 4'h0;
      flag_q    <= 5'h00;
      supply_q  <= `LPW_SUPPLY_RST;
      hide_q    <= 2'h0;
      osc_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      en_q    <= en_d;
      flag_q  <= flag_d;
      if (wr && addr == `LPW_ADDR_SUPPLY) begin
        supply_q <= hwdata[1:0];
      end
      if (state_q == ST_WAKE) begin
        osc_cnt_q <= osc_cnt_q + 8'h01;
      end else begin
        osc_cnt_q <= 8'h00;
      end
      // hide flags two clocks after suspend wake
      if (state_q == ST_WAKE && state_d == ST_RUN) begin
        hide_q <= `LPW_FLAG_HIDE_CYC;
      end else if (hide_q != 2'h0) begin
        hide_q <= hide_q - 2'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // power outputs and bus answer
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sys_clk_en         <= 1'b1;
      osc_en             <= 1'b1;
      core_reg_en        <= 1'b1;
      ram_on_battery     <= 1'b0;
      dcdc_en            <= 1'b1;
      analog_rail_to_bat <= 1'b0;
      analog_rail_float  <= 1'b0;
      cmp_keep_on        <= 1'b1;
      pin_hold           <= 1'b0;
      port_out           <= 8'h00;
      cpu_resume         <= 1'b0;
      low_power_active   <= 1'b0;
      hrdata             <= 32'h00000000;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
    end else begin
      // clock gated in both low-power states
      sys_clk_en       <= (state_d == ST_RUN);
      // oscillators restart as soon as wake begins
      osc_en           <= (state_d == ST_RUN) || (state_d == ST_WAKE);
      // regulator off, ram on battery in sleep
      core_reg_en      <= (state_d != ST_SLEEP);
      ram_on_battery   <= (state_d == ST_SLEEP);
      // converter only in one-cell, off during sleep
      dcdc_en          <= ~two_cell & (state_d != ST_SLEEP);
      cmp_keep_on      <= two_cell | (state_d != ST_SLEEP);
      // rail to battery unless float selected
      analog_rail_to_bat <= (state_d == ST_SLEEP) & ~two_cell
                            & ~supply_q[`LPW_BIT_FLOAT];
      analog_rail_float  <= (state_d == ST_SLEEP) & ~two_cell
                            & supply_q[`LPW_BIT_FLOAT];
      pin_hold         <= (state_d == ST_SLEEP);
      if (state_d != ST_SLEEP) begin
        port_out <= port_out_in;
      end
      cpu_resume       <= (state_q == ST_WAKE) && (state_d == ST_RUN);
      low_power_active <= (state_d != ST_RUN);
      hreadyout        <= 1'b1;
      hresp            <= 1'b0;
      hrdata           <= 32'h00000000;
      if (rd_take && haddr == `LPW_ADDR_PMCFG) begin
        hrdata <= (hide_q != 2'h0) ? 32'h00000000 : {27'h0, flag_q};
      end else if (rd_take && haddr == `LPW_ADDR_SUPPLY) begin
        hrdata <= {30'h0, supply_q};
      end else if (rd_take && haddr == `LPW_ADDR_STATUS) begin
        hrdata <= {24'h0, en_q, state_q};
      end
    end
  end
endmodule // lpw_ctrl

/* lpw_ctrl_assertions.sv */
/*
  checker for the power controls and bus response of lpw_ctrl.
  assumes it is bound to lpw_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
module lpw_ctrl_assertions (
  // clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // bus response
  input wire       hreadyout,
  input wire       hresp,
  // events and pins
  input wire       rst_pin_n,
  input wire [7:0] port_out,
  // power controls
  input wire       sys_clk_en,
  input wire       osc_en,
  input wire       core_reg_en,
  input wire       ram_on_battery,
  input wire       dcdc_en,
  input wire       analog_rail_to_bat,
  input wire       analog_rail_float,
  input wire       cmp_keep_on,
  input wire       pin_hold,
  input wire       cpu_resume
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
  osc_gate_a: assert property (!osc_en |-> !sys_clk_en)
    else $error("clock running with oscillators off");
  sleep_supply_a: assert property (ram_on_battery == !core_reg_en
    && pin_hold == ram_on_battery)
    else $error("sleep supply controls disagree");
  pin_freeze_a: assert property (pin_hold ##1 pin_hold |-> $stable(port_out))
    else $error("held pins changed");
  dcdc_off_a: assert property (ram_on_battery |-> !dcdc_en && !sys_clk_en)
    else $error("converter on in sleep");
  rail_choice_a: assert property ((analog_rail_to_bat || analog_rail_float) |->
    ram_on_battery && !(analog_rail_to_bat && analog_rail_float))
    else $error("analog rail set outside sleep");
  cmp_kept_a: assert property (!cmp_keep_on |-> analog_rail_to_bat || analog_rail_float)
    else $error("comparator dropped outside one-cell sleep");
  rst_wake_a: assert property ($fell(rst_pin_n) && !osc_en |-> ##[1:6] osc_en)
    else $error("reset pin edge did not wake");
  resume_osc_a: assert property (cpu_resume |-> $past(osc_en, 3) && !$past(sys_clk_en, 3))
    else $error("resume without oscillator restart");
  resume_clk_a: assert property (cpu_resume |-> ##[0:1] sys_clk_en)
    else $error("clock not ungated at resume");

  sleep_seen_c: cover property (ram_on_battery);
  susp_seen_c: cover property (!osc_en && !ram_on_battery);
  resume_seen_c: cover property (cpu_resume);
endmodule // lpw_ctrl_assertions

/* lpw_ctrl_tb.sv */
/*
  self-checking bench for lpw_ctrl: register access, entry, wake sources.
  assumes lpw_regs.vh on the include path; one ahb-lite master here.
*/
`timescale 1ns/1ns
`include "lpw_regs.vh"
module lpw_ctrl_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  // rst_pin_n, osc fail, alarm, port match, comparator
  logic [4:0]  ev = 5'h10;
  logic [7:0]  pin_in = 8'h00;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, sys_clk_en, osc_en, core_reg_en;
  logic        ram_on_battery, dcdc_en, rail_bat, rail_flt, cmp_on, pin_hold, cpu_resume;
  logic [7:0]  port_out;
  logic        lp_act;
  logic [31:0] rd;
  int          err_total = 0;
  int          num_checks = 0;

  lpw_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rtc_osc_fail(ev[3]),
    .rtc_alarm(ev[2]), .port_match(ev[1]), .cmp_out(ev[0]), .rst_pin_n(ev[4]),
    .port_out_in(pin_in), .sys_clk_en(sys_clk_en), .osc_en(osc_en),
    .core_reg_en(core_reg_en), .ram_on_battery(ram_on_battery), .dcdc_en(dcdc_en),
    .analog_rail_to_bat(rail_bat), .analog_rail_float(rail_flt), .cmp_keep_on(cmp_on),
    .pin_hold(pin_hold), .port_out(port_out), .cpu_resume(cpu_resume),
    .low_power_active(lp_act));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic close_out;
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // sel 0 bus ready, 1 oscillators off, 2 resume pulse
  task automatic wait_on(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(sel == 0 ? hreadyout === 1'b1 : sel == 1 ? osc_en === 1'b0 :
                 cpu_resume === 1'b1) && n < 100);
    if (n >= 100) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_on(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_on(0);
    rd = hrdata;
  endtask

  task automatic pulse(input int s);
    ev[s] <= ~ev[s];
    tick(2);
    ev[s] <= ~ev[s];
  endtask

  // one entry, optional comparator decoy, wake by src (4 is the reset pin)
  task automatic lp_cycle(input logic [1:0] sup, input logic [7:0] cfg, input int src);
    logic       sl;
    logic       one;
    logic [7:0] held;
    sl = cfg[7];
    one = sl && !sup[0];
    bus(1'b1, `LPW_ADDR_SUPPLY, {30'h0, sup});
    bus(1'b1, `LPW_ADDR_PMCFG, {24'h0, cfg});
    wait_on(1);
    tick(1);
    check("power", {1'b0, !sl, sl, sl, !sl && !sup[0], one && !sup[1], one && sup[1], !one},
      {sys_clk_en, core_reg_en, ram_on_battery, pin_hold, dcdc_en, rail_bat, rail_flt,
       cmp_on});
    check("active", 32'h1, lp_act);
    held = port_out;
    pin_in <= ~pin_in;
    tick(3);
    check("pins", sl ? held : pin_in, port_out);
    if (one) begin
      pulse(0);
      tick(8);
      check("asleep", 32'h0, osc_en);
    end
    pulse(src);
    wait_on(2);
    bus(1'b0, `LPW_ADDR_PMCFG, 32'h0);
    check("hidden", 32'h0, rd);
    bus(1'b0, `LPW_ADDR_PMCFG, 32'h0);
    check("cause", 32'h1 << src, rd);
    bus(1'b0, `LPW_ADDR_STATUS, 32'h0);
    check("status", 32'h1, rd);
    check("awake", 32'h0, lp_act);
    if (src == 4) tick(1875);
    bus(1'b1, `LPW_ADDR_PMCFG, 32'h20);
    bus(1'b0, `LPW_ADDR_PMCFG, 32'h0);
    check("cleared", 32'h0, rd);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    tick(8);
    rst_n <= 1'b1;
    tick(3);
    bus(1'b0, `LPW_ADDR_SUPPLY, 32'h0);
    check("supply", 32'h0, rd);
    bus(1'b0, `LPW_ADDR_STATUS, 32'h0);
    check("status", 32'h1, rd);
    bus(1'b1, 12'h00c, 32'hffffffff);
    bus(1'b0, 12'h00c, 32'h0);
    check("unmapped", 32'h0, rd);
    pulse(2);
    tick(3);
    pulse(1);
    tick(10);
    bus(1'b0, `LPW_ADDR_PMCFG, 32'h0);
    check("flags", 32'h6, rd);
    bus(1'b1, `LPW_ADDR_PMCFG, 32'h44);
    tick(5);
    check("refused", 32'h1, osc_en);
    bus(1'b0, `LPW_ADDR_STATUS, 32'h0);
    check("state", 32'h1, rd & 32'hf);
    bus(1'b1, `LPW_ADDR_PMCFG, 32'h20);
    lp_cycle(2'b01, 8'h81, 0);
    lp_cycle(2'b01, 8'h42, 1);
    lp_cycle(2'b00, 8'h84, 2);
    lp_cycle(2'b00, 8'h48, 3);
    lp_cycle(2'b00, 8'h40, 4);
    lp_cycle(2'b10, 8'h81, 4);
    lp_cycle(2'b01, 8'hc4, 2);
    close_out();
  end
endmodule // lpw_ctrl_tb

bind lpw_ctrl lpw_ctrl_assertions chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .hreadyout(hreadyout), .hresp(hresp), .rst_pin_n(rst_pin_n), .port_out(port_out),
  .sys_clk_en(sys_clk_en), .osc_en(osc_en), .core_reg_en(core_reg_en),
  .ram_on_battery(ram_on_battery), .dcdc_en(dcdc_en), .analog_rail_to_bat(analog_rail_to_bat),
  .analog_rail_float(analog_rail_float), .cmp_keep_on(cmp_keep_on), .pin_hold(pin_hold),
  .cpu_resume(cpu_resume));
